// *** common/pdm_pkg.sv ***
package pdm_pkg;

	// ----------------------------------------------------------------
	// Port geometry
	// ----------------------------------------------------------------
	localparam int PDM_PINS = 8;
	localparam int PDM_DM_W = 3;
	localparam int PDM_USB_LO = 6;
	localparam int PDM_USB_HI = 7;
	localparam logic [7:0] PDM_USB_MASK = 8'hc0;
	localparam logic [7:0] PDM_ALL_MASK = 8'hff;

	// ----------------------------------------------------------------
	// Drive mode codes
	// ----------------------------------------------------------------
	localparam logic [2:0] PDM_DM_HIZ_ANA = 3'h0;
	localparam logic [2:0] PDM_DM_HIZ_DIG = 3'h1;
	localparam logic [2:0] PDM_DM_RES_UP = 3'h2;
	localparam logic [2:0] PDM_DM_RES_DN = 3'h3;
	localparam logic [2:0] PDM_DM_OD_LO = 3'h4;
	localparam logic [2:0] PDM_DM_OD_HI = 3'h5;
	localparam logic [2:0] PDM_DM_STRONG = 3'h6;
	localparam logic [2:0] PDM_DM_RES_UPDN = 3'h7;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [23:0] PDM_RST_DM = 24'h000000;
	localparam logic [7:0] PDM_RST_OUT = 8'h00;
	localparam logic [1:0] PDM_RST_USB = 2'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PDM_SEL_DM0,
		PDM_SEL_DM1,
		PDM_SEL_DM2,
		PDM_SEL_OUT,
		PDM_SEL_BYP_OUT,
		PDM_SEL_BYP_IN,
		PDM_SEL_IRQ_RISE,
		PDM_SEL_IRQ_FALL,
		PDM_SEL_REG_OUT
	} pdm_sel_t;

	typedef struct packed {
		logic irq_fall;
		logic irq_rise;
		logic byp_in;
		logic byp_out;
		logic [2:0] pin_drive_sel;
		logic out_bit;
	} pdm_pin_cfg_t;

	typedef struct packed {
		logic [1:0] usb_pin_pull_bit;
		logic [1:0] usb_pin_drive_bit;
	} pdm_usb_cfg_t;

	typedef struct packed {
		logic hi;
		logic lo;
		logic pu;
		logic pd;
		logic ibuf;
	} pdm_drv_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
		logic [7:0] pu;
		logic [7:0] pd;
		logic [7:0] ibuf;
	} pdm_pad_t;

	typedef struct packed {
		logic [7:0] dm0;
		logic [7:0] dm1;
		logic [7:0] dm2;
		logic [7:0] out_data;
		logic [7:0] byp_out;
		logic [7:0] byp_in;
		logic [7:0] rise_en;
		logic [7:0] fall_en;
		logic [7:0] reg_out;
		logic [1:0] usb_drive;
		logic [1:0] usb_pull;
		logic [7:0] level;
		logic [7:0] ibuf_prev;
		logic [7:0] status;
		logic irq;
		logic [7:0] fab_in;
	} pdm_port_st_t;

endpackage

// *** verilog/pdm_pin_drv.sv ***
`timescale 1ns/1ps

// Decodes the drive selection and data of one pin into registered pad controls.
module pdm_pin_drv (
	input wire logic sys_clk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic [2:0] pin_drive_sel, // Drive mode of this pin.
	input wire logic data_i, // Selected output value.
	input wire logic regulated_i, // Special pin in regulated output mode.
	input wire logic usb_sel_i, // Pin is one of the two USB-capable pins.
	input wire logic usb_mode_i, // USB-capable pins owned by the USB core.
	input wire logic usb_drive_i, // Drive bit of a USB-capable pin.
	input wire logic usb_pull_i, // Pull bit of a USB-capable pin.
	output pdm_pkg::pdm_drv_t drv // Registered pad controls.
);

	pdm_pkg::pdm_drv_t st_q;
	pdm_pkg::pdm_drv_t st_d;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	always_comb begin
		st_d = '0;
		if (usb_sel_i) begin
			if (usb_mode_i) begin
				st_d.ibuf = 1'b1;
			end else begin
				st_d.ibuf = 1'b1;
				st_d.lo = ~data_i;
				st_d.hi = data_i & usb_drive_i;
				st_d.pu = data_i & ~usb_drive_i & usb_pull_i;
			end
		end else begin
			unique case (pin_drive_sel)
				pdm_pkg::PDM_DM_HIZ_ANA: begin
					st_d.ibuf = 1'b0;
				end
				pdm_pkg::PDM_DM_HIZ_DIG: begin
					st_d.ibuf = 1'b1;
				end
				pdm_pkg::PDM_DM_RES_UP: begin
					st_d.ibuf = 1'b1;
					st_d.pu = data_i;
					st_d.lo = ~data_i;
				end
				pdm_pkg::PDM_DM_RES_DN: begin
					st_d.ibuf = 1'b1;
					st_d.hi = data_i;
					st_d.pd = ~data_i;
				end
				pdm_pkg::PDM_DM_OD_LO: begin
					st_d.ibuf = 1'b1;
					st_d.lo = ~data_i;
				end
				pdm_pkg::PDM_DM_OD_HI: begin
					st_d.ibuf = 1'b1;
					st_d.hi = data_i;
				end
				pdm_pkg::PDM_DM_STRONG: begin
					st_d.ibuf = 1'b1;
					st_d.hi = data_i;
					st_d.lo = ~data_i;
				end
				pdm_pkg::PDM_DM_RES_UPDN: begin
					st_d.ibuf = 1'b1;
					st_d.pu = data_i;
					st_d.pd = ~data_i;
				end
			endcase
			if (regulated_i) begin
				st_d.pu = 1'b0;
				st_d.pd = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign drv = st_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_mode_analog;
		@(posedge sys_clk) disable iff (rst)
		(!usb_sel_i && pin_drive_sel == pdm_pkg::PDM_DM_HIZ_ANA) |=> (drv == '0);
	endproperty
	a_mode_analog: assert property (p_mode_analog) else $error("analog mode not fully off");

	property p_mode_digital_hiz;
		@(posedge sys_clk) disable iff (rst)
		(!usb_sel_i && pin_drive_sel == pdm_pkg::PDM_DM_HIZ_DIG)
			|=> (!drv.hi && !drv.lo && !drv.pu && !drv.pd && drv.ibuf);
	endproperty
	a_mode_digital_hiz: assert property (p_mode_digital_hiz) else $error("digital hiz wrong");

	property p_mode_strong;
		@(posedge sys_clk) disable iff (rst)
		(!usb_sel_i && pin_drive_sel == pdm_pkg::PDM_DM_STRONG)
			|=> (drv.hi == $past(data_i) && drv.lo == !$past(data_i));
	endproperty
	a_mode_strong: assert property (p_mode_strong) else $error("strong drive wrong");

	property p_mode_res_both;
		@(posedge sys_clk) disable iff (rst)
		(!usb_sel_i && !regulated_i && pin_drive_sel == pdm_pkg::PDM_DM_RES_UPDN)
			|=> (!drv.hi && !drv.lo && drv.pu == $past(data_i) && drv.pd == !$past(data_i));
	endproperty
	a_mode_res_both: assert property (p_mode_res_both) else $error("resistive mode wrong");

	property p_regulated;
		@(posedge sys_clk) disable iff (rst)
		(!usb_sel_i && regulated_i) |=> (!drv.pu && !drv.pd);
	endproperty
	a_regulated: assert property (p_regulated) else $error("resistor in regulated mode");

	property p_usb_io;
		@(posedge sys_clk) disable iff (rst)
		(usb_sel_i && !usb_mode_i && !data_i) |=> (drv.lo && !drv.hi && !drv.pu && !drv.pd);
	endproperty
	a_usb_io: assert property (p_usb_io) else $error("usb pin low drive wrong");

	property p_usb_owned;
		@(posedge sys_clk) disable iff (rst)
		(usb_sel_i && usb_mode_i) |=> (!drv.hi && !drv.lo && !drv.pu && !drv.pd);
	endproperty
	a_usb_owned: assert property (p_usb_owned) else $error("usb mode pin driven");

endmodule

// *** verilog/pdm_port.sv ***
`timescale 1ns/1ps

// What this block does
// - Each pin has its own 3-bit drive select.
// - Reset gives analog hiz, driver and buffer off on every pin; from the first clock after reset the USB-capable pins drive low with buffer on.
// - Mode 1: driver off, input buffer on.
// - Modes 2/3: resistive one side, strong other.
// - Modes 4/5: open drain low or high.
// - Mode 6: strong drive both levels.
// - Mode 7: resistive pull-up and pull-down.
// - Regulated special pin: no resistive modes.
// - Output from fabric when bypassed, else register.
// - Pin level to read register and fabric.
// - Read level separate from stored output data.
// - Per-pin rising, falling or both edge interrupts.
// - One interrupt request line per port.
// - Port-form and pin-form writes share state.
// - USB pin drive bit: open drain or strong.
// - USB pin pull bit adds pull-up high in open drain only.
// - USB mode ignores USB pin drive bits.
// - Port-wide writes never touch USB drive bits.
// - Port reset state is user programmable.
module pdm_port #(
	parameter logic HAS_USB = 1'b1,
	parameter logic [23:0] RST_DRIVE_SEL = pdm_pkg::PDM_RST_DM,
	parameter logic [7:0] RST_OUT = pdm_pkg::PDM_RST_OUT
) (
	input wire logic sys_clk, // System clock, 20 MHz.
	input wire logic rst, // Asynchronous reset, active high.
	input wire logic cfg_wr, // Port-form write strobe, one cycle.
	input pdm_pkg::pdm_sel_t cfg_sel, // Port-form register select.
	input wire logic [7:0] cfg_data, // Port-form write data, bit n is pin n.
	input wire logic pin_wr, // Pin-form write strobe, one cycle.
	input wire logic [2:0] pin_idx, // Pin addressed by a pin-form write.
	input pdm_pkg::pdm_pin_cfg_t pin_data, // Pin-form write data.
	input wire logic usb_wr, // Write strobe for the USB pin bits.
	input pdm_pkg::pdm_usb_cfg_t usb_data, // USB pin drive and pull bits.
	input wire logic usb_mode, // USB pins owned by the USB core.
	input wire logic [7:0] irq_clr, // Clear mask for edge status, one cycle.
	input wire logic [7:0] pin_in, // Sampled pin levels.
	input wire logic [7:0] fab_out, // Output values from the routing fabric.
	output pdm_pkg::pdm_pad_t pad, // Pad driver and input buffer controls.
	output logic [7:0] fab_in, // Pin levels to the routing fabric.
	output logic [7:0] pin_level_reg, // Readable pin levels.
	output logic [7:0] out_data_reg, // Readable stored output data.
	output logic [23:0] drive_mode_cfg, // Readable drive select planes.
	output logic [7:0] irq_status, // Sticky edge status per pin.
	output logic irq_req // Port interrupt request.
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam pdm_pkg::pdm_port_st_t RST_ST = '{
		dm0: RST_DRIVE_SEL[7:0],
		dm1: RST_DRIVE_SEL[15:8],
		dm2: RST_DRIVE_SEL[23:16],
		out_data: RST_OUT,
		usb_drive: pdm_pkg::PDM_RST_USB,
		usb_pull: pdm_pkg::PDM_RST_USB,
		default: '0
	};
	localparam logic [7:0] DM_MASK = HAS_USB ? ~pdm_pkg::PDM_USB_MASK : pdm_pkg::PDM_ALL_MASK;

	pdm_pkg::pdm_port_st_t st_q;
	pdm_pkg::pdm_port_st_t st_d;
	logic [7:0] out_val;
	logic [7:0] ibuf_w;
	logic [7:0] lvl_now;
	logic [7:0] rise_ev;
	logic [7:0] fall_ev;
	logic [7:0] edge_ev;
	logic [7:0] sel;
	logic pin_dm_ok;

	assign ibuf_w = pad.ibuf;

	// ----------------------------------------------------------------
	// Output source and input path
	// ----------------------------------------------------------------
	always_comb begin
		out_val = (st_q.byp_out & fab_out) | (~st_q.byp_out & st_q.out_data);
		lvl_now = pin_in & ibuf_w;
		rise_ev = lvl_now & ~st_q.level & st_q.rise_en & ibuf_w & st_q.ibuf_prev;
		fall_ev = ~lvl_now & st_q.level & st_q.fall_en & ibuf_w & st_q.ibuf_prev;
		edge_ev = rise_ev | fall_ev;
		sel = 8'h01 << pin_idx;
		pin_dm_ok = !(HAS_USB && (pin_idx == 3'(pdm_pkg::PDM_USB_LO)
			|| pin_idx == 3'(pdm_pkg::PDM_USB_HI)));
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Port form: each bit is one pin.
		if (cfg_wr) begin
			unique case (cfg_sel)
				pdm_pkg::PDM_SEL_DM0: begin
					st_d.dm0 = (st_q.dm0 & ~DM_MASK) | (cfg_data & DM_MASK);
				end
				pdm_pkg::PDM_SEL_DM1: begin
					st_d.dm1 = (st_q.dm1 & ~DM_MASK) | (cfg_data & DM_MASK);
				end
				pdm_pkg::PDM_SEL_DM2: begin
					st_d.dm2 = (st_q.dm2 & ~DM_MASK) | (cfg_data & DM_MASK);
				end
				pdm_pkg::PDM_SEL_OUT: begin
					st_d.out_data = cfg_data;
				end
				pdm_pkg::PDM_SEL_BYP_OUT: begin
					st_d.byp_out = cfg_data;
				end
				pdm_pkg::PDM_SEL_BYP_IN: begin
					st_d.byp_in = cfg_data;
				end
				pdm_pkg::PDM_SEL_IRQ_RISE: begin
					st_d.rise_en = cfg_data;
				end
				pdm_pkg::PDM_SEL_IRQ_FALL: begin
					st_d.fall_en = cfg_data;
				end
				pdm_pkg::PDM_SEL_REG_OUT: begin
					st_d.reg_out = cfg_data;
				end
				default: begin
					st_d.out_data = st_q.out_data;
				end
			endcase
		end
		// Pin form: one pin, same storage; a pin write wins over a port write.
		if (pin_wr) begin
			st_d.out_data = (st_d.out_data & ~sel) | ({8{pin_data.out_bit}} & sel);
			st_d.byp_out = (st_d.byp_out & ~sel) | ({8{pin_data.byp_out}} & sel);
			st_d.byp_in = (st_d.byp_in & ~sel) | ({8{pin_data.byp_in}} & sel);
			st_d.rise_en = (st_d.rise_en & ~sel) | ({8{pin_data.irq_rise}} & sel);
			st_d.fall_en = (st_d.fall_en & ~sel) | ({8{pin_data.irq_fall}} & sel);
			if (pin_dm_ok) begin
				st_d.dm0 = (st_d.dm0 & ~sel) | ({8{pin_data.pin_drive_sel[0]}} & sel);
				st_d.dm1 = (st_d.dm1 & ~sel) | ({8{pin_data.pin_drive_sel[1]}} & sel);
				st_d.dm2 = (st_d.dm2 & ~sel) | ({8{pin_data.pin_drive_sel[2]}} & sel);
			end
		end
		// The USB pin bits have their own write path only.
		if (usb_wr) begin
			st_d.usb_drive = usb_data.usb_pin_drive_bit;
			st_d.usb_pull = usb_data.usb_pin_pull_bit;
		end
		// Input capture, kept apart from the stored output data.
		st_d.level = lvl_now;
		st_d.fab_in = lvl_now & st_q.byp_in;
		st_d.ibuf_prev = ibuf_w;
		// An edge in the clearing cycle is kept.
		st_d.status = (st_q.status & ~irq_clr) | edge_ev;
		st_d.irq = |st_d.status;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_q <= RST_ST;
		end else begin
			st_q <= st_d;
		end
	end

	// ----------------------------------------------------------------
	// Per-pin drivers
	// ----------------------------------------------------------------
	for (genvar i = 0; i < pdm_pkg::PDM_PINS; i++) begin : g_pin
		pdm_pkg::pdm_drv_t drv_w;
		logic usb_pin;
		logic usb_bit;
		assign usb_pin = HAS_USB && (i == pdm_pkg::PDM_USB_LO || i == pdm_pkg::PDM_USB_HI);
		assign usb_bit = (i == pdm_pkg::PDM_USB_HI);
		pdm_pin_drv u_drv (
			.sys_clk(sys_clk),
			.rst(rst),
			.pin_drive_sel({st_q.dm2[i], st_q.dm1[i], st_q.dm0[i]}),
			.data_i(out_val[i]),
			.regulated_i(st_q.reg_out[i]),
			.usb_sel_i(usb_pin),
			.usb_mode_i(usb_mode),
			.usb_drive_i(st_q.usb_drive[usb_bit]),
			.usb_pull_i(st_q.usb_pull[usb_bit]),
			.drv(drv_w)
		);
		assign pad.hi[i] = drv_w.hi;
		assign pad.lo[i] = drv_w.lo;
		assign pad.pu[i] = drv_w.pu;
		assign pad.pd[i] = drv_w.pd;
		assign pad.ibuf[i] = drv_w.ibuf;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign fab_in = st_q.fab_in;
	assign pin_level_reg = st_q.level;
	assign out_data_reg = st_q.out_data;
	assign drive_mode_cfg = {st_q.dm2, st_q.dm1, st_q.dm0};
	assign irq_status = st_q.status;
	assign irq_req = st_q.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_level_gated;
		@(posedge sys_clk) disable iff (rst)
		##1 (pin_level_reg == ($past(pin_in) & $past(ibuf_w)));
	endproperty
	a_level_gated: assert property (p_level_gated) else $error("pin level not gated");

	property p_out_kept;
		@(posedge sys_clk) disable iff (rst)
		(!cfg_wr && !pin_wr) |=> $stable(out_data_reg);
	endproperty
	a_out_kept: assert property (p_out_kept) else $error("output data changed");

	property p_irq_line;
		@(posedge sys_clk) disable iff (rst)
		irq_req == (|irq_status);
	endproperty
	a_irq_line: assert property (p_irq_line) else $error("irq line mismatch");

	property p_edge_sets;
		@(posedge sys_clk) disable iff (rst)
		(|edge_ev) |=> ((irq_status & $past(edge_ev)) == $past(edge_ev));
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("edge event lost");

	property p_usb_bits;
		@(posedge sys_clk) disable iff (rst)
		!usb_wr |=> $stable(st_q.usb_drive);
	endproperty
	a_usb_bits: assert property (p_usb_bits) else $error("usb drive bits changed");

	property p_fab_in;
		@(posedge sys_clk) disable iff (rst)
		##1 (fab_in == (pin_level_reg & $past(st_q.byp_in)));
	endproperty
	a_fab_in: assert property (p_fab_in) else $error("fabric input wrong");

endmodule

// *** sim/pdm_board.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External board circuitry
// ----------------------------------------------------------------
// Resolves the pad controls against an optional external driver.
// A pin that nobody holds wanders every cycle, so a stale level never passes.
module pdm_board (
	input wire logic sys_clk, // System clock.
	input wire logic rst, // Asynchronous reset, active high.
	input pdm_pkg::pdm_pad_t pad, // Pad controls from the port.
	input wire logic [7:0] ext_en, // External driver enable per pin.
	input wire logic [7:0] ext, // External driver level per pin.
	output logic [7:0] pin_in // Resolved pin levels.
);
	logic [7:0] float_q;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			float_q <= 8'h55;
		end else begin
			float_q <= ~float_q;
		end
	end

	// Strong drive beats the external driver, which beats the resistors.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			pin_in[i] = pad.hi[i] ? 1'h1 : pad.lo[i] ? 1'h0 : ext_en[i] ? ext[i] :
				pad.pu[i] ? 1'h1 : pad.pd[i] ? 1'h0 : float_q[i];
		end
	end
endmodule

// *** sim/test_pin_drive_mode_port.sv ***
`timescale 1ns/1ps

module test_pin_drive_mode_port;
	localparam int PAD = 0;
	localparam int DMC = 1;
	localparam int ODR = 2;
	localparam int LVL = 3;
	localparam int FIN = 4;
	localparam int IST = 5;
	localparam int IRQ = 6;
	localparam logic [39:0] FULL = 40'hffffffffff;

	typedef struct {int id; logic [39:0] exp; logic [39:0] mask;} pdm_note_t;

	logic sys_clk, rst, cfg_wr, pin_wr, usb_wr, usb_mode, irq_req, r_d;
	pdm_pkg::pdm_sel_t cfg_sel;
	pdm_pkg::pdm_pin_cfg_t pin_data;
	pdm_pkg::pdm_usb_cfg_t usb_data;
	pdm_pkg::pdm_pad_t pad;
	logic [7:0] cfg_data, irq_clr, pin_in, fab_out, fab_in, pin_level_reg, out_data_reg;
	logic [7:0] irq_status, ext_en, ext, out_m, r_f;
	logic [2:0] pin_idx, r_idx, r_m;
	logic [23:0] drive_mode_cfg, dm_m;
	logic [39:0] seen;
	pdm_note_t notes[$];
	pdm_note_t n;
	event look;
	int failures = 0;
	int checks = 0;
	string nm[7] = '{"pad", "drive_mode_cfg", "out_data_reg", "pin_level_reg", "fab_in",
		"irq_status", "irq_req"};

	pdm_port dut (.sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr), .cfg_sel(cfg_sel),
		.cfg_data(cfg_data), .pin_wr(pin_wr), .pin_idx(pin_idx), .pin_data(pin_data),
		.usb_wr(usb_wr), .usb_data(usb_data), .usb_mode(usb_mode), .irq_clr(irq_clr),
		.pin_in(pin_in), .fab_out(fab_out), .pad(pad), .fab_in(fab_in),
		.pin_level_reg(pin_level_reg), .out_data_reg(out_data_reg),
		.drive_mode_cfg(drive_mode_cfg), .irq_status(irq_status), .irq_req(irq_req));

	pdm_board board (.sys_clk(sys_clk), .rst(rst), .pad(pad), .ext_en(ext_en), .ext(ext),
		.pin_in(pin_in));

	// ----------------------------------------------------------------
	// Clock, watchdog and result watcher
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'h0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		#(4000 * 50);
		failures++;
		summarize();
	end

	initial begin
		forever begin
			@(look);
			while (notes.size() > 0) begin
				n = notes.pop_front();
				case (n.id)
					PAD: seen = pad;
					DMC: seen = {16'h0, drive_mode_cfg};
					ODR: seen = {32'h0, out_data_reg};
					LVL: seen = {32'h0, pin_level_reg};
					FIN: seen = {32'h0, fab_in};
					IST: seen = {32'h0, irq_status};
					default: seen = {39'h0, irq_req};
				endcase
				check(nm[n.id], seen & n.mask, n.exp & n.mask);
			end
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [39:0] s, input logic [39:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, e, s);
		end
	endtask

	task automatic note(input int id, input logic [39:0] e, input logic [39:0] m);
		notes.push_back('{id, e, m});
		->look;
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Expected pad bits {hi, lo, pu, pd, ibuf} of one pin; r marks regulated output.
	function automatic logic [4:0] pb(input logic [2:0] m, input logic d, input logic r);
		case (m)
			3'h0: pb = 5'h00;
			3'h1: pb = 5'h01;
			3'h2: pb = d ? {2'h0, ~r, 2'h1} : 5'h09;
			3'h3: pb = d ? 5'h11 : {3'h0, ~r, 1'h1};
			3'h4: pb = d ? 5'h01 : 5'h09;
			3'h5: pb = d ? 5'h11 : 5'h01;
			3'h6: pb = d ? 5'h11 : 5'h09;
			default: pb = d ? {2'h0, ~r, 2'h1} : {3'h0, ~r, 1'h1};
		endcase
	endfunction

	function automatic logic [39:0] sp(input logic [4:0] b, input logic [7:0] m);
		for (int f = 0; f < 5; f++) begin
			sp[f * 8 +: 8] = b[f] ? m : 8'h00;
		end
	endfunction

	task automatic idle(input int c);
		repeat (c) @(posedge sys_clk) begin
			cfg_wr <= 1'h0;
			pin_wr <= 1'h0;
			usb_wr <= 1'h0;
			irq_clr <= 8'h00;
		end
		@(negedge sys_clk);
	endtask

	task automatic cfg(input pdm_pkg::pdm_sel_t s, input logic [7:0] v);
		@(posedge sys_clk);
		cfg_wr <= 1'h1;
		cfg_sel <= s;
		cfg_data <= v;
	endtask

	task automatic set_all(input logic [2:0] m, input logic d);
		cfg(pdm_pkg::PDM_SEL_DM0, {8{m[0]}});
		cfg(pdm_pkg::PDM_SEL_DM1, {8{m[1]}});
		cfg(pdm_pkg::PDM_SEL_DM2, {8{m[2]}});
		cfg(pdm_pkg::PDM_SEL_OUT, {8{d}});
		idle(3);
		dm_m = {2'h0, {6{m[2]}}, 2'h0, {6{m[1]}}, 2'h0, {6{m[0]}}};
		out_m = {8{d}};
	endtask

	task automatic clr();
		@(posedge sys_clk);
		cfg_wr <= 1'h0;
		irq_clr <= 8'hff;
		idle(2);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst = 1'h1;
		{cfg_wr, pin_wr, usb_wr, usb_mode} = 4'h0;
		cfg_sel = pdm_pkg::PDM_SEL_DM0;
		{cfg_data, irq_clr, fab_out, ext_en, ext, out_m} = 48'h0;
		{pin_idx, pin_data, usb_data, dm_m} = 39'h0;
		void'($urandom(94484));
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		@(negedge sys_clk);
		note(PAD, 40'h0, FULL);
		note(DMC, 40'h0, FULL);
		note(LVL, 40'h0, FULL);
		note(IRQ, 40'h0, FULL);
		$display("test reset done");
		for (int s = 0; s < 2; s++) begin
			cfg(pdm_pkg::PDM_SEL_REG_OUT, s[0] ? 8'hff : 8'h00);
			for (int m = 0; m < 8; m++) begin
				for (int d = 0; d < 2; d++) begin
					set_all(3'(m), d[0]);
					note(PAD, sp(pb(3'(m), d[0], s[0]), 8'h3f), sp(5'h1f, 8'h3f));
					note(DMC, {16'h0, dm_m}, FULL);
				end
			end
		end
		cfg(pdm_pkg::PDM_SEL_REG_OUT, 8'h00);
		$display("test drive modes done");
		repeat (8) begin
			r_idx = 3'($urandom_range(5, 0));
			r_m = 3'($urandom_range(7, 0));
			r_d = 1'($urandom_range(1, 0));
			@(posedge sys_clk);
			cfg_wr <= 1'h0;
			pin_wr <= 1'h1;
			pin_idx <= r_idx;
			pin_data <= {4'h0, r_m, r_d};
			idle(3);
			{dm_m[16 + r_idx], dm_m[8 + r_idx], dm_m[r_idx]} = r_m;
			out_m[r_idx] = r_d;
			note(DMC, {16'h0, dm_m}, FULL);
			note(ODR, {32'h0, out_m}, FULL);
			note(PAD, sp(pb(r_m, r_d, 1'h0), 8'h01 << r_idx), sp(5'h1f, 8'h01 << r_idx));
		end
		@(posedge sys_clk);
		pin_wr <= 1'h1;
		pin_idx <= 3'h7;
		pin_data <= {4'h0, 3'h6, 1'h0};
		idle(3);
		out_m[7] = 1'h0;
		note(DMC, {16'h0, dm_m}, FULL);
		note(ODR, {32'h0, out_m}, FULL);
		$display("test pin form done");
		set_all(3'h6, 1'h0);
		cfg(pdm_pkg::PDM_SEL_BYP_OUT, 8'h3f);
		cfg(pdm_pkg::PDM_SEL_BYP_IN, 8'hff);
		r_f = 8'($urandom);
		fab_out <= r_f;
		idle(4);
		note(PAD, {r_f, ~r_f, 24'h0}, {16'h3f3f, 24'h0});
		note(FIN, {32'h0, r_f}, 40'h3f);
		cfg(pdm_pkg::PDM_SEL_BYP_OUT, 8'h00);
		$display("test bypass done");
		@(posedge sys_clk);
		cfg_wr <= 1'h0;
		ext_en <= 8'hff;
		ext <= 8'h00;
		set_all(3'h1, 1'h1);
		note(ODR, {32'h0, out_m}, FULL);
		note(LVL, 40'h0, FULL);
		cfg(pdm_pkg::PDM_SEL_IRQ_RISE, 8'h05);
		cfg(pdm_pkg::PDM_SEL_IRQ_FALL, 8'h06);
		clr();
		@(posedge sys_clk);
		ext <= 8'hff;
		idle(3);
		note(IST, 40'h05, FULL);
		note(IRQ, 40'h1, FULL);
		note(LVL, 40'hff, FULL);
		clr();
		note(IST, 40'h0, FULL);
		note(IRQ, 40'h0, FULL);
		@(posedge sys_clk);
		ext <= 8'h00;
		idle(3);
		note(IST, 40'h06, FULL);
		clr();
		set_all(3'h0, 1'h0);
		@(posedge sys_clk);
		ext <= 8'hff;
		idle(3);
		note(IST, 40'h0, 40'h3f);
		note(LVL, 40'h0, 40'h3f);
		$display("test edges done");
		@(posedge sys_clk);
		ext_en <= 8'h00;
		cfg(pdm_pkg::PDM_SEL_OUT, 8'h80);
		for (int k = 0; k < 4; k++) begin
			@(posedge sys_clk);
			cfg_wr <= 1'h0;
			usb_wr <= 1'h1;
			usb_data <= {{2{k[1]}}, {2{k[0]}}};
			idle(3);
			note(PAD, {k[0], 15'h0040, ~k[0] & k[1], 15'h0, 8'hc0}, sp(5'h1f, 8'hc0));
		end
		@(posedge sys_clk);
		usb_mode <= 1'h1;
		idle(3);
		note(PAD, 40'hc0, sp(5'h1f, 8'hc0));
		$display("test usb pins done");
		idle(1);
		summarize();
	end
endmodule
